// ---- hibc_consts.svh ----
// register offsets, field positions, reset values and timing counts of the hibernation control block
`ifndef HIBC_CONSTS_SVH
`define HIBC_CONSTS_SVH

// ==============================
// register byte offsets
`define HIBC_OFS_COUNT      6'h00
`define HIBC_OFS_MATCH0     6'h04
`define HIBC_OFS_MATCH1     6'h08
`define HIBC_OFS_LOAD       6'h0C
`define HIBC_OFS_CTRL       6'h10
`define HIBC_OFS_IMASK      6'h14
`define HIBC_OFS_ISTAT      6'h18
`define HIBC_OFS_STATE      6'h1C

// ==============================
// control field positions
`define HIBC_CTL_RUN        0
`define HIBC_CTL_SLEEP      1
`define HIBC_CTL_CLKSRC     2
`define HIBC_CTL_MATCHWK    3
`define HIBC_CTL_PINWK      4
`define HIBC_CTL_LOWBAT     5
`define HIBC_CTL_WIDTH      6

// ==============================
// event bit positions in status and mask
`define HIBC_EV_MATCH0      0
`define HIBC_EV_MATCH1      1
`define HIBC_EV_LOWBAT      2
`define HIBC_EV_PIN         3
`define HIBC_EV_WIDTH       4

// ==============================
// reset values
`define HIBC_MATCH_RST      32'hFFFFFFFF
`define HIBC_LOAD_RST       32'hFFFFFFFF
`define HIBC_CTRL_RST       6'h00

// ==============================
// slow clock timing: 32768 module clock ticks make one second
`define HIBC_PRESCALE       7'h7F
`define HIBC_TICKS_PER_SEC  15'h7FFF

`endif

// ---- hibc_pkg.sv ----
// types shared by the hibernation control block
package hibc_pkg;
	typedef enum logic [1:0] {
		HIBC_AWAKE,
		HIBC_ENTERING,
		HIBC_ASLEEP
	} hibc_pwr_t;
endpackage

// ---- hibc_tick_div.sv ----
// slow clock prescaler: divides a tick enable by a programmable terminal count
`timescale 1ns/1ps
module hibc_tick_div #(
	parameter int W = 7
) (
	input  wire logic         core_clk, // system clock
	input  wire logic         resetn,   // synchronous reset, active low
	input  wire logic         in_tick,  // input enable pulse
	input  wire logic [W-1:0] term,     // terminal count, divides by term+1
	input  wire logic         bypass,   // pass input straight through
	output logic              out_tick  // output enable pulse, registered
);
	logic [W-1:0] cnt_r;

	// count input ticks, wrap at the terminal value
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cnt_r <= '0;
		end else if (in_tick) begin
			cnt_r <= (cnt_r == term) ? '0 : cnt_r + 1'b1;
		end
	end

	// emit one pulse per wrap, or every tick when bypassed
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			out_tick <= 1'b0;
		end else begin
			out_tick <= in_tick & (bypass | (cnt_r == term));
		end
	end
endmodule

// ---- hibc_ctrl.sv ----
// hibernation control: control register, real-time counter, match wake-up and wishbone slave
// Notes on behaviour
// - low battery enable on: flag when backup supply below threshold; off: no detection
// - pin wake-up enable on: pin event restores power; off: pin events ignored
// - match wake-up enable on: counter equal to either match restores power
// - clock source select 0 divides slow clock by 128; 1 uses it raw
// - writing sleep request starts hibernation; hardware clears it after wake-up
// - two 32-bit match registers compared to counter give match events
`timescale 1ns/1ps
`include "hibc_consts.svh"
module hibc_ctrl #(
	parameter int AW = 6,  // wishbone address width
	parameter int VW = 8   // supply level comparison width
) (
	input  wire logic          core_clk,       // 125 MHz system clock
	input  wire logic          resetn,         // synchronous reset, active low
	input  wire logic [AW-1:0] wb_adr_i,       // byte address
	input  wire logic [31:0]   wb_dat_i,       // write data
	input  wire logic [3:0]    wb_sel_i,       // byte enables
	input  wire logic          wb_we_i,        // write enable
	input  wire logic          wb_cyc_i,       // cycle valid
	input  wire logic          wb_stb_i,       // strobe
	output logic [31:0]        wb_dat_o,       // read data
	output logic               wb_ack_o,       // acknowledge
	input  wire logic          slow_tick,      // one-cycle pulse per slow clock edge
	input  wire logic          wake_pin_n,     // external wake pin, active low
	input  wire logic [VW-1:0] backup_supply_level,     // measured backup supply
	input  wire logic [VW-1:0] backup_supply_threshold, // low-battery threshold
	output logic               power_cut,      // high while the chip is unpowered
	output logic               low_battery,    // low battery condition
	output logic               irq             // level interrupt
);
	import hibc_pkg::*;

	// ==============================
	// state
	logic [`HIBC_CTL_WIDTH-1:0] ctrl_r;
	logic [31:0]                count_r;
	logic [31:0]                alarm_match_zero;
	logic [31:0]                alarm_match_one;
	logic [31:0]                load_r;
	logic [`HIBC_EV_WIDTH-1:0]  istat_r;
	logic [`HIBC_EV_WIDTH-1:0]  imask_r;
	logic [14:0]                sec_cnt_r;
	logic                       pin_d_r;
	logic                       mod_tick;
	logic                       sec_tick_r;
	logic                       match0_hit;
	logic                       match1_hit;
	logic                       lowbat_now;
	logic                       pin_event;
	logic                       wake_event;
	logic                       acc;
	logic                       wr;
	logic                       rd;
	logic [31:0]                wmask;
	logic [31:0]                rdata;
	hibc_pwr_t                  pwr_r;

	wire counter_run_enable             = ctrl_r[`HIBC_CTL_RUN];
	wire sleep_entry_request            = ctrl_r[`HIBC_CTL_SLEEP];
	wire slow_clock_source_select       = ctrl_r[`HIBC_CTL_CLKSRC];
	wire counter_match_wakeup_enable    = ctrl_r[`HIBC_CTL_MATCHWK];
	wire external_pin_wakeup_enable     = ctrl_r[`HIBC_CTL_PINWK];
	wire low_battery_monitor_enable     = ctrl_r[`HIBC_CTL_LOWBAT];

	// ==============================
	// bus decode
	assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr  = acc & wb_we_i;
	assign rd  = acc & ~wb_we_i;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// ==============================
	// module clock: slow tick divided by 128 or raw
	hibc_tick_div #(
		.W (7)
	) u_prescale (
		.core_clk (core_clk),
		.resetn   (resetn),
		.in_tick  (slow_tick),
		.term     (`HIBC_PRESCALE),
		.bypass   (slow_clock_source_select),
		.out_tick (mod_tick)
	);

	// second tick from the module clock
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sec_cnt_r  <= '0;
			sec_tick_r <= 1'b0;
		end else begin
			sec_tick_r <= 1'b0;
			if (mod_tick) begin
				sec_cnt_r  <= (sec_cnt_r == `HIBC_TICKS_PER_SEC) ? '0 : sec_cnt_r + 1'b1;
				sec_tick_r <= (sec_cnt_r == `HIBC_TICKS_PER_SEC);
			end
		end
	end

	// ==============================
	// event detection
	assign match0_hit = (count_r == alarm_match_zero);
	assign match1_hit = (count_r == alarm_match_one);
	assign lowbat_now = low_battery_monitor_enable &
		(backup_supply_level < backup_supply_threshold);
	assign pin_event  = pin_d_r & ~wake_pin_n;
	assign wake_event = (pin_event & external_pin_wakeup_enable) |
		((match0_hit | match1_hit) & counter_match_wakeup_enable);

	// pin falling edge detector
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			pin_d_r <= 1'b1;
		end else begin
			pin_d_r <= wake_pin_n;
		end
	end

	// low battery output
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			low_battery <= 1'b0;
		end else begin
			low_battery <= lowbat_now;
		end
	end

	// ==============================
	// real-time counter: load on write, advance on second tick
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			count_r <= '0;
		end else if (wr && wb_adr_i == `HIBC_OFS_LOAD) begin
			count_r <= (load_r & ~wmask) | (wb_dat_i & wmask);
		end else if (sec_tick_r && counter_run_enable) begin
			count_r <= count_r + 32'h00000001;
		end
	end

	// match and load registers
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			alarm_match_zero <= `HIBC_MATCH_RST;
			alarm_match_one  <= `HIBC_MATCH_RST;
			load_r           <= `HIBC_LOAD_RST;
		end else if (wr) begin
			if (wb_adr_i == `HIBC_OFS_MATCH0) begin
				alarm_match_zero <= (alarm_match_zero & ~wmask) | (wb_dat_i & wmask);
			end else if (wb_adr_i == `HIBC_OFS_MATCH1) begin
				alarm_match_one <= (alarm_match_one & ~wmask) | (wb_dat_i & wmask);
			end else if (wb_adr_i == `HIBC_OFS_LOAD) begin
				load_r <= (load_r & ~wmask) | (wb_dat_i & wmask);
			end
		end
	end

	// ==============================
	// control register; hardware clear of the sleep request wins over a write
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ctrl_r <= `HIBC_CTRL_RST;
		end else begin
			if (wr && wb_adr_i == `HIBC_OFS_CTRL && wb_sel_i[0]) begin
				ctrl_r <= wb_dat_i[`HIBC_CTL_WIDTH-1:0];
			end
			if (pwr_r == HIBC_ASLEEP && wake_event) begin
				ctrl_r[`HIBC_CTL_SLEEP] <= 1'b0;
			end
		end
	end

	// power sequencer
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			pwr_r     <= HIBC_AWAKE;
			power_cut <= 1'b0;
		end else begin
			case (pwr_r)
				HIBC_AWAKE: begin
					if (sleep_entry_request) begin
						pwr_r <= HIBC_ENTERING;
					end
				end
				HIBC_ENTERING: begin
					pwr_r     <= HIBC_ASLEEP;
					power_cut <= 1'b1;
				end
				HIBC_ASLEEP: begin
					if (wake_event) begin
						pwr_r     <= HIBC_AWAKE;
						power_cut <= 1'b0;
					end
				end
				default: begin
					pwr_r <= HIBC_AWAKE;
				end
			endcase
		end
	end

	// ==============================
	// interrupts: sticky status, set wins over clear-on-read
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			istat_r <= '0;
			imask_r <= '0;
		end else begin
			if (rd && wb_adr_i == `HIBC_OFS_ISTAT) begin
				istat_r <= '0;
			end
			if (match0_hit) begin
				istat_r[`HIBC_EV_MATCH0] <= 1'b1;
			end
			if (match1_hit) begin
				istat_r[`HIBC_EV_MATCH1] <= 1'b1;
			end
			if (lowbat_now) begin
				istat_r[`HIBC_EV_LOWBAT] <= 1'b1;
			end
			if (pin_event & external_pin_wakeup_enable) begin
				istat_r[`HIBC_EV_PIN] <= 1'b1;
			end
			if (wr && wb_adr_i == `HIBC_OFS_IMASK && wb_sel_i[0]) begin
				imask_r <= wb_dat_i[`HIBC_EV_WIDTH-1:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(istat_r & imask_r);
		end
	end

	// ==============================
	// read mux
	always_comb begin
		rdata = 32'h00000000;
		if (wb_adr_i == `HIBC_OFS_COUNT) begin
			rdata = count_r;
		end else if (wb_adr_i == `HIBC_OFS_MATCH0) begin
			rdata = alarm_match_zero;
		end else if (wb_adr_i == `HIBC_OFS_MATCH1) begin
			rdata = alarm_match_one;
		end else if (wb_adr_i == `HIBC_OFS_LOAD) begin
			rdata = load_r;
		end else if (wb_adr_i == `HIBC_OFS_CTRL) begin
			rdata[`HIBC_CTL_WIDTH-1:0] = ctrl_r;
		end else if (wb_adr_i == `HIBC_OFS_IMASK) begin
			rdata[`HIBC_EV_WIDTH-1:0] = imask_r;
		end else if (wb_adr_i == `HIBC_OFS_ISTAT) begin
			rdata[`HIBC_EV_WIDTH-1:0] = istat_r;
		end else if (wb_adr_i == `HIBC_OFS_STATE) begin
			rdata[1:0] = pwr_r;
		end
	end

	// ack one cycle after the strobe, unmapped reads return zero
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= acc;
			wb_dat_o <= rd ? rdata : 32'h00000000;
		end
	end
endmodule

// ---- hibc_ctrl_assertions.sv ----
// concurrent checks on the ports of the hibernation control block
`timescale 1ns/1ps
`include "hibc_consts.svh"
module hibc_chk #(
	parameter int AW = 6, // address width
	parameter int VW = 8  // level width
) (
	input wire logic          core_clk,                // clock
	input wire logic          resetn,                  // reset, low
	input wire logic [AW-1:0] wb_adr_i,                // address
	input wire logic [31:0]   wb_dat_i,                // write data
	input wire logic [3:0]    wb_sel_i,                // byte enables
	input wire logic          wb_we_i,                 // write
	input wire logic          wb_cyc_i,                // cycle
	input wire logic          wb_stb_i,                // strobe
	input wire logic [31:0]   wb_dat_o,                // read data
	input wire logic          wb_ack_o,                // ack
	input wire logic          slow_tick,               // slow tick
	input wire logic          wake_pin_n,              // wake pin
	input wire logic [VW-1:0] backup_supply_level,     // supply
	input wire logic [VW-1:0] backup_supply_threshold, // threshold
	input wire logic          power_cut,               // power off
	input wire logic          low_battery,             // low flag
	input wire logic          irq                      // interrupt
);
	logic [5:3] en_r;  // shadow of wake and low battery enables
	logic [3:0] msk_r; // shadow of the mask
	logic       tk;    // request taken this edge
	logic       lt;    // supply below threshold
	assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign lt = backup_supply_level < backup_supply_threshold;
	// shadow registers follow taken writes with the low byte enabled
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			en_r <= 3'h0;
			msk_r <= 4'h0;
		end else if (tk && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == `HIBC_OFS_CTRL) en_r <= wb_dat_i[5:3];
			if (wb_adr_i == `HIBC_OFS_IMASK) msk_r <= wb_dat_i[3:0];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// ==============================
	// bus, power and flag relations
	property p_ack; tk |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_lb_on; (en_r[5] && lt) [*2] |-> low_battery; endproperty
	a_lb_on: assert property (p_lb_on) else $error("low flag missing");
	property p_lb_off; (!en_r[5] || !lt) [*2] |-> !low_battery; endproperty
	a_lb_off: assert property (p_lb_off) else $error("low flag spurious");
	property p_pin; power_cut && en_r[4] && $fell(wake_pin_n) |-> ##[1:4] !power_cut; endproperty
	a_pin: assert property (p_pin) else $error("pin wake missing");
	property p_hold; power_cut && en_r[4:3] == 2'h0 |=> power_cut; endproperty
	a_hold: assert property (p_hold) else $error("wake while disabled");
	property p_sleep;
		tk && wb_we_i && wb_sel_i[0] && wb_adr_i == `HIBC_OFS_CTRL && wb_dat_i[1]
			&& wb_dat_i[4:3] == 2'h0 |-> ##[2:5] power_cut;
	endproperty
	a_sleep: assert property (p_sleep) else $error("no sleep entry");
	property p_irq; (msk_r == 4'h0) [*2] |-> !irq; endproperty
	a_irq: assert property (p_irq) else $error("irq while masked");
endmodule
bind hibc_ctrl hibc_chk #(.AW(AW), .VW(VW)) hibc_chk_inst (.core_clk(core_clk),
	.resetn(resetn), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
	.wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .slow_tick(slow_tick), .wake_pin_n(wake_pin_n),
	.backup_supply_level(backup_supply_level),
	.backup_supply_threshold(backup_supply_threshold), .power_cut(power_cut),
	.low_battery(low_battery), .irq(irq));

// ---- testbench.sv ----
// self-checking bench for the hibernation control block
`timescale 1ns/1ps
`include "hibc_consts.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
	$display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (e)); end end
module testbench;
	logic        core_clk, resetn, wb_we_i, wb_cyc_i, wb_stb_i, slow_tick, wake_pin_n;
	logic        wb_ack_o, power_cut, low_battery, irq;
	logic [5:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q, d;
	logic [7:0]  lvl, thr;
	int          fails, tests_run, cyc_n;
	logic [5:0]  oa [9] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20};
	logic [31:0] ov [9] = '{32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0,
		32'h0, 32'h0, 32'h0};
	hibc_ctrl hibc_ctrl_inst (.core_clk(core_clk), .resetn(resetn), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .slow_tick(slow_tick),
		.wake_pin_n(wake_pin_n), .backup_supply_level(lvl), .backup_supply_threshold(thr),
		.power_cut(power_cut), .low_battery(low_battery), .irq(irq));
	// clock and hang guard
	initial begin
		core_clk = 1'h0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc_n++;
		if (cyc_n == 100000) begin
			fails++;
			summarize();
		end
	end
	// ==============================
	// tasks
	task summarize;
		$display("counts: %0d compared, %0d failed", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task wt(input int c);
		repeat (c) @(posedge core_clk);
	endtask
	// one classic cycle, held until ack is sampled high
	task xf(input logic [5:0] a, input logic w, input logic [31:0] v);
		@(posedge core_clk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_adr_i <= a;
		wb_we_i <= w;
		wb_dat_i <= v;
		// ack sampled high ends this wait, or else the bench timeout
		do begin
			@(posedge core_clk);
		end while (wb_ack_o !== 1'h1);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		wb_we_i <= 1'h0;
	endtask
	task rd(input logic [5:0] a, input logic [31:0] e);
		xf(a, 1'h0, 32'h0);
		`CHK(q, e)
	endtask
	task pc(input logic v, input int lim);
		int k;
		k = 0;
		while (power_cut !== v && k < lim) begin
			@(posedge core_clk);
			k++;
		end
		`CHK(power_cut, v)
	endtask
	task pulse;
		wake_pin_n <= 1'h0;
		wt(2);
		wake_pin_n <= 1'h1;
		wt(6);
	endtask
	// expected control value once hardware drops the sleep request
	function automatic logic [31:0] woke(input logic [31:0] c);
		return c & ~32'h2;
	endfunction
	// ==============================
	// main sequence
	initial begin
		void'($urandom(32'hFA5E));
		{resetn, wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} = '0;
		{slow_tick, wake_pin_n, wb_sel_i, lvl, thr} = {2'h3, 4'hF, 16'h8000};
		wt(6);
		resetn <= 1'h1;
		for (int i = 0; i < 9; i++) rd(oa[i], ov[i]);
		d = $urandom;
		xf(`HIBC_OFS_MATCH1, 1'h1, d);
		rd(`HIBC_OFS_MATCH1, d);
		$display("register test done");
		thr <= 8'($urandom_range(255, 1));
		wt(1);
		lvl <= 8'($urandom_range(thr - 1, 0));
		xf(`HIBC_OFS_CTRL, 1'h1, 32'h20);
		wt(3);
		`CHK(low_battery, 1'h1)
		`CHK(irq, 1'h0)
		xf(`HIBC_OFS_IMASK, 1'h1, 32'h4);
		wt(2);
		`CHK(irq, 1'h1)
		lvl <= thr;
		wt(3);
		`CHK(low_battery, 1'h0)
		rd(`HIBC_OFS_ISTAT, 32'h4);
		wt(2);
		`CHK(irq, 1'h0)
		xf(`HIBC_OFS_CTRL, 1'h1, 32'h0);
		lvl <= 8'h0;
		wt(3);
		`CHK(low_battery, 1'h0)
		rd(`HIBC_OFS_ISTAT, 32'h0);
		$display("low battery test done");
		xf(`HIBC_OFS_CTRL, 1'h1, 32'h2);
		pc(1'h1, 8);
		rd(`HIBC_OFS_STATE, 32'h2);
		pulse();
		`CHK(power_cut, 1'h1)
		xf(`HIBC_OFS_CTRL, 1'h1, 32'h12);
		pulse();
		pc(1'h0, 8);
		rd(`HIBC_OFS_CTRL, woke(32'h12));
		rd(`HIBC_OFS_ISTAT, 32'h8);
		$display("pin wake test done");
		xf(`HIBC_OFS_CTRL, 1'h1, 32'h4);
		wt(33000);
		rd(`HIBC_OFS_COUNT, 32'h0);
		xf(`HIBC_OFS_CTRL, 1'h1, 32'h1);
		wt(33000);
		rd(`HIBC_OFS_COUNT, 32'h0);
		$display("counter hold test done");
		xf(`HIBC_OFS_LOAD, 1'h1, 32'h4);
		xf(`HIBC_OFS_MATCH0, 1'h1, 32'h5);
		xf(`HIBC_OFS_CTRL, 1'h1, 32'hF);
		pc(1'h1, 8);
		pc(1'h0, 33100);
		rd(`HIBC_OFS_COUNT, 32'h5);
		rd(`HIBC_OFS_CTRL, woke(32'hF));
		rd(`HIBC_OFS_ISTAT, 32'h1);
		$display("match wake test done");
		summarize();
	end
endmodule
